// ### design/timer_consts.vh
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_CHAN_ENABLE 12'h004
`define OFS_TIME_BASE_SEL 12'h008
`define OFS_IRQ_ENABLE 12'h00C
`define OFS_TIMEOUT_FLAG 12'h010
`define OFS_FORCE_LOAD 12'h014
`define OFS_MICRO_LOAD0 12'h018
`define OFS_MICRO_LOAD1 12'h01C
`define OFS_LOAD_BASE 12'h020
`define OFS_COUNT_BASE 12'h040

// Word and channel fields of the byte address, and end of the count block
`define ADDR_WORD_LSB 2
`define ADDR_CHAN_MSB 4
`define OFS_COUNT_END 12'h060

// Control register fields
`define CTRL_MODULE_EN 0
`define CTRL_FORCE_MICRO0 1
`define CTRL_FORCE_MICRO1 2

// Reset values
`define RST_MICRO_LOAD 8'h00
`define RST_LOAD 16'h0000
`define RST_WORD 32'h0000_0000

`endif

// ### design/periodic_timeout_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "timer_consts.vh"

// Summary of operation
// - Timer array reaching 24-bit time-out range
// - Period equals m times n bus cycles
// - 8-bit micro counter clocks 16-bit counters
// - Each channel has own modulus period
// - Channels enabled separately and independently
// - Each channel drives own trigger output
// - Force-load starts several channels aligned
// - Select bit picks micro base 0/1
// - Select change takes effect immediately
// - Interrupt enable gates time-out flag
// - Pending flag interrupts at once when enabled
module periodic_timeout_timer #(
    parameter CHANNELS = 8,
    parameter CNT_WIDTH = 16,
    parameter MICRO_WIDTH = 8
) (
    input wire pclk, // Bus clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    output reg [CHANNELS-1:0] trigger, // Time-out triggers
    output reg irq // Level interrupt
);

// ****************************************
// Registers
// ****************************************
reg module_en;
reg [CHANNELS-1:0] chan_enable;
reg [CHANNELS-1:0] time_base_select;
reg [CHANNELS-1:0] timeout_irq_enable;
reg [CHANNELS-1:0] timeout_flag;
reg [MICRO_WIDTH-1:0] micro_load0;
reg [MICRO_WIDTH-1:0] micro_load1;
// Two micro time bases feed every channel
localparam BASES = 2;
wire [CNT_WIDTH*CHANNELS-1:0] load_flat;
wire [CNT_WIDTH*CHANNELS-1:0] count_flat;

// ****************************************
// Bus decode
// ****************************************
// Request taken while pready is low; pready answers one edge
// later and a write lands only on that completing edge
wire access = psel && penable && !pready;
wire done = psel && penable && pready;
wire wr = done && pwrite;
wire [11:0] word_addr = {paddr[11:`ADDR_WORD_LSB],
    {`ADDR_WORD_LSB{1'b0}}};
wire in_load = word_addr >= `OFS_LOAD_BASE &&
    word_addr < `OFS_COUNT_BASE;
wire in_count = word_addr >= `OFS_COUNT_BASE &&
    word_addr < `OFS_COUNT_END;
wire [2:0] sel_chan = word_addr[`ADDR_CHAN_MSB:`ADDR_WORD_LSB];
// Slots past the last channel answer as unmapped
wire chan_ok = {29'd0, sel_chan} < CHANNELS;

// ****************************************
// Write strobes
// ****************************************
wire wr_ctrl = wr && word_addr == `OFS_CONTROL;
wire wr_chan_en = wr && word_addr == `OFS_CHAN_ENABLE;
wire wr_base_sel = wr && word_addr == `OFS_TIME_BASE_SEL;
wire wr_irq_en = wr && word_addr == `OFS_IRQ_ENABLE;
wire wr_flag = wr && word_addr == `OFS_TIMEOUT_FLAG;
wire wr_force = wr && word_addr == `OFS_FORCE_LOAD;
wire wr_mload0 = wr && word_addr == `OFS_MICRO_LOAD0;
wire wr_mload1 = wr && word_addr == `OFS_MICRO_LOAD1;
wire wr_load = wr && in_load && chan_ok;

// Channel bits sit in the low bits of the word
wire [CHANNELS-1:0] wdata_bits = pwdata[CHANNELS-1:0];
wire [CHANNELS-1:0] force_mask = wr_force ?
    wdata_bits : {CHANNELS{1'b0}};
wire [CHANNELS-1:0] clear_mask = wr_flag ?
    wdata_bits : {CHANNELS{1'b0}};

wire [BASES-1:0] force_micro = {
    wr_ctrl && pwdata[`CTRL_FORCE_MICRO1],
    wr_ctrl && pwdata[`CTRL_FORCE_MICRO0]};

// ****************************************
// Micro time bases
// ****************************************
wire [BASES-1:0] tick;
// Reload values side by side for the loop
wire [BASES*MICRO_WIDTH-1:0] micro_load_flat = {micro_load1,
    micro_load0};
genvar b;
generate
    for (b = 0; b < BASES; b = b + 1) begin : base
        reg [MICRO_WIDTH-1:0] micro_cnt;
        wire [MICRO_WIDTH-1:0] reload =
            micro_load_flat[b*MICRO_WIDTH +: MICRO_WIDTH];
        assign tick[b] = module_en &&
            micro_cnt == {MICRO_WIDTH{1'b0}};

        // Held at reload while stopped, so a start is clean
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                micro_cnt <= `RST_MICRO_LOAD;
            end else begin
                if (force_micro[b] || tick[b] || !module_en) begin
                    micro_cnt <= reload;
                end else begin
                    micro_cnt <= micro_cnt - 1'b1;
                end
            end
        end
    end
endgenerate

// ****************************************
// Channel counters
// ****************************************
// m times n spans 24 bits
wire [CHANNELS-1:0] expire;
genvar g;
generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
        reg [CNT_WIDTH-1:0] load_val;
        reg [CNT_WIDTH-1:0] count;
        reg [CNT_WIDTH-1:0] next_count;
        wire chan_tick = time_base_select[g] ? tick[1] : tick[0];
        wire active = module_en && chan_enable[g];
        wire at_zero = count == {CNT_WIDTH{1'b0}};
        assign expire[g] = active && chan_tick && at_zero;
        assign load_flat[g*CNT_WIDTH +: CNT_WIDTH] = load_val;
        assign count_flat[g*CNT_WIDTH +: CNT_WIDTH] = count;

        // Stopped channel sits at its load value
        always @* begin
            next_count = count;
            if (!active || force_mask[g]) begin
                next_count = load_val;
            end else if (expire[g]) begin
                next_count = load_val;
            end else if (chan_tick) begin
                next_count = count - 1'b1;
            end
        end

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                load_val <= `RST_LOAD;
                count <= `RST_LOAD;
            end else begin
                if (wr_load && sel_chan == g) begin
                    load_val <= pwdata[CNT_WIDTH-1:0];
                end
                count <= next_count;
            end
        end
    end
endgenerate

// ****************************************
// Control registers
// ****************************************
// cleared and stopped
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        module_en <= 1'b0;
    end else begin
        if (wr_ctrl) begin
            module_en <= pwdata[`CTRL_MODULE_EN];
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        chan_enable <= {CHANNELS{1'b0}};
    end else begin
        if (wr_chan_en) begin
            chan_enable <= wdata_bits;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        time_base_select <= {CHANNELS{1'b0}};
    end else begin
        if (wr_base_sel) begin
            time_base_select <= wdata_bits;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        timeout_irq_enable <= {CHANNELS{1'b0}};
    end else begin
        if (wr_irq_en) begin
            timeout_irq_enable <= wdata_bits;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        micro_load0 <= `RST_MICRO_LOAD;
        micro_load1 <= `RST_MICRO_LOAD;
    end else begin
        if (wr_mload0) begin
            micro_load0 <= pwdata[MICRO_WIDTH-1:0];
        end
        if (wr_mload1) begin
            micro_load1 <= pwdata[MICRO_WIDTH-1:0];
        end
    end
end

// ****************************************
// Flags, triggers and interrupt
// ****************************************
// Set wins over write-one-to-clear, so no time-out is lost
wire [CHANNELS-1:0] next_flag = (timeout_flag & ~clear_mask) | expire;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        timeout_flag <= {CHANNELS{1'b0}};
    end else begin
        timeout_flag <= next_flag;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        trigger <= {CHANNELS{1'b0}};
    end else begin
        trigger <= expire;
    end
end

wire next_irq = |(timeout_flag & timeout_irq_enable);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq <= 1'b0;
    end else begin
        irq <= next_irq;
    end
end

// ****************************************
// Read data
// ****************************************
reg [31:0] next_prdata;
reg next_err;

always @* begin
    next_prdata = `RST_WORD;
    next_err = 1'b0;
    case (word_addr)
        `OFS_CONTROL:
            next_prdata[`CTRL_MODULE_EN] = module_en;
        `OFS_CHAN_ENABLE:
            next_prdata[CHANNELS-1:0] = chan_enable;
        `OFS_TIME_BASE_SEL:
            next_prdata[CHANNELS-1:0] = time_base_select;
        `OFS_IRQ_ENABLE:
            next_prdata[CHANNELS-1:0] = timeout_irq_enable;
        `OFS_TIMEOUT_FLAG:
            next_prdata[CHANNELS-1:0] = timeout_flag;
        // Force load is a strobe and reads as zero
        `OFS_FORCE_LOAD:
            next_prdata = `RST_WORD;
        `OFS_MICRO_LOAD0:
            next_prdata[MICRO_WIDTH-1:0] = micro_load0;
        `OFS_MICRO_LOAD1:
            next_prdata[MICRO_WIDTH-1:0] = micro_load1;
        default: begin
            if (in_load && chan_ok) begin
                next_prdata[CNT_WIDTH-1:0] =
                    load_flat[sel_chan*CNT_WIDTH +: CNT_WIDTH];
            end else if (in_count && chan_ok) begin
                next_prdata[CNT_WIDTH-1:0] =
                    count_flat[sel_chan*CNT_WIDTH +: CNT_WIDTH];
            end else begin
                next_err = 1'b1;
            end
        end
    endcase
end

// ****************************************
// Bus answer
// ****************************************
// One wait state: the answer is registered
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
    end else begin
        pready <= access;
    end
end

// Unmapped words answer with an error
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pslverr <= 1'b0;
    end else begin
        pslverr <= access && next_err;
    end
end

// Read data holds until the next read
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= `RST_WORD;
    end else begin
        if (access && !pwrite) begin
            prdata <= next_prdata;
        end
    end
end

endmodule
`default_nettype wire

// ### dv/timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module timer_monitor #(parameter CHANNELS = 8) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [CHANNELS-1:0] trigger, // Triggers
    input wire logic irq // Interrupt
);
    // ********
    // Bus and event relations
    // ********
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && !pready;
    wire wz = acc && pwrite && pwdata[7:0] == 8'h00;
    property p_answer; acc |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no ready");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_idle; !(psel && penable) |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("ready while idle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unmap; acc && paddr == 12'hFFC |=> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("no error flag");
    property p_hold; !(psel && penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_irq_off; wz && paddr == 12'h00C |=> ##2 !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq stays");
    property p_stop; wz && paddr == 12'h004 |=> ##2 (trigger == 0)[*2];
    endproperty
    a_stop: assert property (p_stop) else $error("trigger runs");
endmodule
bind periodic_timeout_timer timer_monitor #(.CHANNELS(CHANNELS)) i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger(trigger), .irq(irq));
`default_nettype wire

// ### dv/periodic_timeout_timer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module periodic_timeout_timer_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rdata;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [7:0] trigger;
    int error_cnt = 0, checks = 0, cyc = 0, n;
    // Address beside value written and read back
    logic [43:0] rows [7] = '{{12'h008, 32'h0000_00A5},
        {12'h00C, 32'h0000_0000}, {12'h018, 32'h0000_0001},
        {12'h01C, 32'h0000_0003}, {12'h020, 32'h0000_0002},
        {12'h024, 32'h0000_0001}, {12'h008, 32'h0000_0002}};
    periodic_timeout_timer i_periodic_timeout_timer (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger(trigger), .irq(irq));
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task chk(input logic [31:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            $display("wrong value %s exp %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask
    // Idle cycle first, so psel never changes twice in one step
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task meas(input int ch, input int exp);
        n = 0;
        do @(posedge pclk); while (trigger[ch] !== 1'b1);
        do begin
            @(posedge pclk);
            n++;
        end while (trigger[ch] !== 1'b1);
        chk(n, exp, "period");
    endtask
    task report_and_stop;
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        chk({irq, trigger}, 0, "outputs");
        presetn <= 1;
        xfer(0, 12'h008, 0);
        chk(rdata, 0, "select");
        xfer(0, 12'h00C, 0);
        chk(rdata, 0, "irq enable");
        foreach (rows[i]) begin
            xfer(1, rows[i][43:32], rows[i][31:0]);
            xfer(0, rows[i][43:32], 0);
            chk(rdata, rows[i][31:0], "register");
        end
        xfer(1, 12'h000, 1);
        xfer(1, 12'h004, 3);
        xfer(1, 12'h014, 3);
        meas(0, 6);
        meas(1, 8);
        xfer(1, 12'h008, 3);
        meas(0, 12);
        xfer(1, 12'h004, 1);
        xfer(1, 12'h010, 32'h0000_00FF);
        meas(0, 12);
        xfer(0, 12'h010, 0);
        chk(rdata, 1, "flags");
        chk(irq, 0, "irq masked");
        xfer(1, 12'h00C, 1);
        repeat (2) @(posedge pclk);
        chk(irq, 1, "irq pending");
        xfer(1, 12'h004, 0);
        xfer(1, 12'h010, 32'h0000_00FF);
        repeat (2) @(posedge pclk);
        chk(irq, 0, "irq cleared");
        xfer(1, 12'h00C, 0);
        xfer(0, 12'hFFC, 0);
        chk(slv, 1, "unmapped error");
        chk(rdata, 0, "unmapped read");
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        xfer(0, 12'h008, 0);
        chk(rdata, 0, "select after reset");
        xfer(0, 12'h000, 0);
        chk(rdata, 0, "control after reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
